/* src/sync_rx_completion_status.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_rx_completion_status (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control/status word access
    input wire logic csr_wr,
    input wire logic [sync_rx_pkg::CSR_W-1:0] csr_wdata,
    input wire logic csr_rd,
    output logic [sync_rx_pkg::CSR_W-1:0] csr_rdata,
    // character count load strobes
    input wire logic cnt_load_prim,
    input wire logic cnt_load_sec,
    // receiver character stream
    input wire logic rx_valid,
    input wire sync_rx_pkg::rx_char_s rx_char,
    output logic rx_ready,
    // receiver mode and error summary
    input wire logic bit_oriented,
    input wire logic rx_err,
    // memory transfer side
    output logic dma_valid,
    output logic [sync_rx_pkg::CHAR_W-1:0] dma_data,
    input wire logic dma_ready,
    // receive vector request
    output logic irq_req,
    // serial path
    input wire logic tx_serial,
    input wire logic tx_clk_sel,
    input wire logic line_rxd,
    input wire logic line_rx_clk,
    output logic line_txd,
    output logic rx_serial,
    output logic rx_clk
);
    import sync_rx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [N_BUFS-1:0] done;
        logic [N_BUFS-1:0] xfer;
        logic [N_BUFS-1:0][RESID_W-1:0] resid;
        logic ie;
        logic loop;
        logic [CSR_W-1:0] rdata;
        logic [N_PINS-1:0][SYNC_STAGES-1:0] sync;
        logic [N_PINS-1:0] filt;
        logic txd;
        logic rxs;
        logic rxc;
    } stat_state_s;

    stat_state_s q, d;

    rx_entry_s fifo_in;
    rx_entry_s head;
    logic push;
    logic pop;
    logic msg_end;
    logic drain_last;
    logic [N_BUFS-1:0] cnt_load;
    logic [N_BUFS-1:0] resid_flag;
    logic [N_BUFS-1:0] ready_irq;
    logic [N_PINS-1:0] pin_in;
    logic [N_PINS-1:0][SYNC_STAGES-1:0] sync_d;
    logic [N_PINS-1:0] filt_d;
    logic [CSR_W-1:0] word;

    ////////////////////////////////////////////////////////////////////////
    // staging buffer between receiver and memory transfer

    // flags set as characters enter, so done can lead the transfer
    assign fifo_in.bufsel = rx_char.bufsel;
    assign fifo_in.last = rx_char.last;
    assign fifo_in.data = rx_char.data;

    sync_rx_stage_fifo u_stage (
        .clk(clk),
        .srst(srst),
        .wr_valid(rx_valid),
        .wr_data(fifo_in),
        .wr_ready(rx_ready),
        .rd_valid(dma_valid),
        .rd_data(head),
        .rd_ready(dma_ready)
    );

    assign dma_data = head.data;
    assign push = rx_valid && rx_ready;
    assign pop = dma_valid && dma_ready;
    assign msg_end = push && rx_char.last;
    assign drain_last = pop && head.last;
    assign cnt_load = {cnt_load_sec, cnt_load_prim};

    ////////////////////////////////////////////////////////////////////////
    // per-buffer flags and per-pin synchronisers

    genvar gi;
    generate
        for (gi = 0; gi < N_BUFS; gi++) begin : g_buf
            // no stored flag, so it can never disagree with the count
            assign resid_flag[gi] = bit_oriented && (q.resid[gi] != RESID_RST);
            // done alone is not enough: the last character must be gone
            assign ready_irq[gi] = q.done[gi] && q.xfer[gi];
        end
        for (gi = 0; gi < N_PINS; gi++) begin : g_pin
            // first stage feeds only the second; filter looks at 2 and 3
            assign sync_d[gi] = {q.sync[gi][1:0], pin_in[gi]};
            assign filt_d[gi] = (q.sync[gi][1] == q.sync[gi][2]) ? q.sync[gi][2] : q.filt[gi];
        end
    endgenerate

    assign pin_in[PIN_RXD] = line_rxd;
    assign pin_in[PIN_RXC] = line_rx_clk;

    ////////////////////////////////////////////////////////////////////////
    // status word image

    always_comb begin
        word = CSR_ZERO;
        word[BIT_DONE_P] = q.done[BUF_P];
        word[BIT_ERR] = rx_err;
        word[BIT_RESID_P] = resid_flag[BUF_P];
        word[BIT_RESID_S] = resid_flag[BUF_S];
        word[BIT_UNUSED_HI] = 1'b0;
        word[BIT_UNUSED_LO] = 1'b0;
        word[BIT_LOOP] = q.loop;
        word[BIT_DONE_S] = q.done[BUF_S];
        word[BIT_IE] = q.ie;
    end

    // request: enable and any completed buffer or error
    assign irq_req = q.ie && ((|ready_irq) || rx_err);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        // count load clears first, so a message end in the same cycle wins
        for (int b = 0; b < N_BUFS; b++) begin
            if (cnt_load[b]) begin
                d.done[b] = 1'b0;
                d.xfer[b] = 1'b0;
                d.resid[b] = RESID_RST;
            end
        end
        // a message end in the same cycle overrides an older last character leaving, so that newer message is not marked as sent
        if (drain_last) begin
            d.xfer[head.bufsel] = 1'b1;
        end
        if (msg_end) begin
            d.done[rx_char.bufsel] = 1'b1;
            d.xfer[rx_char.bufsel] = 1'b0;
            d.resid[rx_char.bufsel] = rx_char.resid;
        end
        // only the enable and loop bits are writable here
        if (csr_wr) begin
            d.ie = csr_wdata[BIT_IE];
            d.loop = csr_wdata[BIT_LOOP];
        end
        if (csr_rd) begin
            d.rdata = word;
        end
        d.sync = sync_d;
        d.filt = filt_d;
        // serial path steering
        if (q.loop) begin
            d.txd = LINE_MARK;
            d.rxs = tx_serial;
            d.rxc = tx_clk_sel;
        end else begin
            d.txd = tx_serial;
            d.rxs = q.filt[PIN_RXD];
            d.rxc = q.filt[PIN_RXC];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            q.done <= DONE_RST;
            q.xfer <= XFER_RST;
            q.resid <= '0;
            q.ie <= IE_RST;
            q.loop <= LOOP_RST;
            q.txd <= LINE_MARK;
            q.rxs <= LINE_MARK;
        end else begin
            q <= d;
        end
    end

    assign csr_rdata = q.rdata;
    assign line_txd = q.txd;
    assign rx_serial = q.rxs;
    assign rx_clk = q.rxc;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_end_sec;
        msg_end && rx_char.bufsel && !cnt_load_sec;
    endsequence

    sequence s_drain_sec;
        drain_last && head.bufsel && q.done[BUF_S] && !cnt_load_sec && !msg_end;
    endsequence

    AST_DONE_S_SET: assert property (@(posedge clk) disable iff (srst)
        s_end_sec |=> q.done[BUF_S] && !q.xfer[BUF_S])
        else $error("secondary done did not set at message end");

    AST_DONE_S_CLR: assert property (@(posedge clk) disable iff (srst)
        cnt_load_sec && !(msg_end && rx_char.bufsel) ##1 !(msg_end && rx_char.bufsel) ##1 csr_rd
            |=> !csr_rdata[BIT_DONE_S])
        else $error("secondary done clear check");

    AST_DONE_S_GONE: assert property (@(posedge clk) disable iff (srst)
        cnt_load_sec && !(msg_end && rx_char.bufsel) |=> !q.done[BUF_S])
        else $error("secondary done survived count load");

    AST_RESET_VALS: assert property (@(posedge clk)
        $fell(srst) |-> q.done == DONE_RST && q.resid == '0 && !q.loop)
        else $error("wrong values after reset");

    AST_IRQ_AFTER_DRAIN: assert property (@(posedge clk) disable iff (srst)
        s_drain_sec ##0 q.ie ##1 q.ie |-> irq_req)
        else $error("no request after last character left");

    AST_NO_EARLY_IRQ: assert property (@(posedge clk) disable iff (srst)
        s_end_sec ##1 (!rx_err && !ready_irq[BUF_P] && !drain_last) [*2] |-> !irq_req)
        else $error("request before last character left");

    AST_IRQ_ENABLE: assert property (@(posedge clk) disable iff (srst)
        !q.ie |-> !irq_req)
        else $error("request with enable clear");

    AST_RESID_S_READ: assert property (@(posedge clk) disable iff (srst)
        csr_rd |=> csr_rdata[BIT_RESID_S] == $past(bit_oriented && (q.resid[BUF_S] != RESID_RST)))
        else $error("secondary residual flag wrong");

    AST_RESID_P_READ: assert property (@(posedge clk) disable iff (srst)
        csr_rd |=> csr_rdata[BIT_RESID_P] == $past(bit_oriented && (q.resid[BUF_P] != RESID_RST)))
        else $error("primary residual flag wrong");

    AST_RESID_CLR: assert property (@(posedge clk) disable iff (srst)
        cnt_load_sec && !(msg_end && rx_char.bufsel) |=> q.resid[BUF_S] == RESID_RST)
        else $error("secondary residual not cleared");

    AST_RESID_P_CLR: assert property (@(posedge clk) disable iff (srst)
        cnt_load_prim && !(msg_end && !rx_char.bufsel) |=> q.resid[BUF_P] == RESID_RST)
        else $error("primary residual not cleared");

    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (srst)
        csr_rd |=> csr_rdata[BIT_UNUSED_HI:BIT_UNUSED_LO] == 2'h0)
        else $error("unused bits not zero");

    AST_LOOP_WRITE: assert property (@(posedge clk) disable iff (srst)
        csr_wr |=> q.loop == $past(csr_wdata[BIT_LOOP]))
        else $error("loop bit not stored");

    AST_LOOP_PATH: assert property (@(posedge clk) disable iff (srst)
        q.loop |=> line_txd == LINE_MARK && rx_serial == $past(tx_serial) && rx_clk == $past(tx_clk_sel))
        else $error("loop path wrong");

    // with the loop off the line must carry the transmitter unchanged
    AST_LOOP_OFF: assert property (@(posedge clk) disable iff (srst)
        !q.loop |=> line_txd == $past(tx_serial))
        else $error("line data does not follow transmitter");

    AST_IRQ_ERR: assert property (@(posedge clk) disable iff (srst)
        q.ie && rx_err |-> irq_req)
        else $error("no request for receive error");

    AST_DONE_S_HOLD: assert property (@(posedge clk) disable iff (srst)
        q.done[BUF_S] && !cnt_load_sec |=> q.done[BUF_S])
        else $error("secondary done dropped without count load");

    AST_RESID_HIDDEN: assert property (@(posedge clk) disable iff (srst)
        csr_rd && !bit_oriented |=> csr_rdata[BIT_RESID_P:BIT_RESID_S] == 2'h0)
        else $error("residual flags shown outside bit-oriented mode");

endmodule : sync_rx_completion_status

`default_nettype wire

/* src/sync_rx_pkg.sv */
package sync_rx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned CSR_W = 16;
    localparam int unsigned CHAR_W = 8;
    localparam int unsigned RESID_W = 3;
    localparam int unsigned N_BUFS = 2;

    ////////////////////////////////////////////////////////////////////////
    // control/status word field positions
    localparam int unsigned BIT_IE = 5;
    localparam int unsigned BIT_DONE_S = 7;
    localparam int unsigned BIT_LOOP = 8;
    localparam int unsigned BIT_UNUSED_LO = 9;
    localparam int unsigned BIT_UNUSED_HI = 10;
    localparam int unsigned BIT_RESID_S = 11;
    localparam int unsigned BIT_RESID_P = 12;
    localparam int unsigned BIT_ERR = 14;
    localparam int unsigned BIT_DONE_P = 15;

    // buffer index: 0 primary, 1 secondary
    localparam int unsigned BUF_P = 0;
    localparam int unsigned BUF_S = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [N_BUFS-1:0] DONE_RST = 2'h3;
    localparam logic [N_BUFS-1:0] XFER_RST = 2'h3;
    localparam logic [RESID_W-1:0] RESID_RST = 3'h0;
    localparam logic IE_RST = 1'b0;
    localparam logic LOOP_RST = 1'b0;
    localparam logic LINE_MARK = 1'b1;
    localparam logic [CSR_W-1:0] CSR_ZERO = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // on-board staging buffer
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_AW = 3;
    localparam int unsigned FIFO_CW = 4;
    localparam logic [FIFO_CW-1:0] FIFO_FULL = 4'h8;

    // pin synchroniser
    localparam int unsigned SYNC_STAGES = 3;
    localparam int unsigned N_PINS = 2;
    localparam int unsigned PIN_RXD = 0;
    localparam int unsigned PIN_RXC = 1;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic bufsel;
        logic last;
        logic [CHAR_W-1:0] data;
    } rx_entry_s;

    typedef struct packed {
        logic bufsel;
        logic last;
        logic [RESID_W-1:0] resid;
        logic [CHAR_W-1:0] data;
    } rx_char_s;

endpackage : sync_rx_pkg

/* src/sync_rx_stage_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_rx_stage_fifo (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // fill side
    input wire logic wr_valid,
    input wire sync_rx_pkg::rx_entry_s wr_data,
    output logic wr_ready,
    // drain side
    output logic rd_valid,
    output sync_rx_pkg::rx_entry_s rd_data,
    input wire logic rd_ready
);
    import sync_rx_pkg::*;

    typedef struct packed {
        rx_entry_s [FIFO_DEPTH-1:0] mem;
        logic [FIFO_AW-1:0] wptr;
        logic [FIFO_AW-1:0] rptr;
        logic [FIFO_CW-1:0] cnt;
        logic ov;
        rx_entry_s od;
    } fifo_state_s;

    fifo_state_s q, d;
    logic push;
    logic pop_out;
    logic load;

    // handshakes; head sits in a register so read data leave a flop
    assign wr_ready = (q.cnt != FIFO_FULL);
    assign rd_valid = q.ov;
    assign rd_data = q.od;
    assign push = wr_valid && wr_ready;
    assign pop_out = q.ov && rd_ready;
    assign load = (q.cnt != 4'h0) && (!q.ov || pop_out);

    // next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wptr] = wr_data;
            d.wptr = q.wptr + 3'h1;
        end
        if (load) begin
            d.od = q.mem[q.rptr];
            d.ov = 1'b1;
            d.rptr = q.rptr + 3'h1;
        end else if (pop_out) begin
            d.ov = 1'b0;
        end
        d.cnt = q.cnt + {3'h0, push} - {3'h0, load};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : sync_rx_stage_fifo

`default_nettype wire

/* testbench/mem_sink.sv */
`timescale 1ns/1ps
`default_nettype none

module mem_sink (
    // clock
    input wire logic clk,
    // memory transfer side
    input wire logic dma_valid,
    output logic dma_ready,
    // test control: hold off all transfers
    input wire logic stall
);
    import sync_rx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // random acceptance, changed off the sampling edge
    // a slow memory exercises the head register hold behaviour
    initial dma_ready = 1'b0;
    always @(negedge clk) begin
        dma_ready <= !stall && dma_valid && ($urandom_range(0, 3) != 0);
    end
endmodule : mem_sink

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sync_rx_pkg::*;
    logic clk = 0, srst = 1, csr_wr = 0, csr_rd = 0, cnt_load_prim = 0, cnt_load_sec = 0;
    logic rx_valid = 0, bit_oriented = 0, rx_err = 0, stall = 1, rd_p = 0;
    logic tx_serial = 0, tx_clk_sel = 0, line_rxd = 0, line_rx_clk = 0;
    logic rx_ready, dma_valid, dma_ready, irq_req, line_txd, rx_serial, rx_clk, ts, tc, lr;
    logic [CSR_W-1:0] csr_wdata = CSR_ZERO;
    logic [CSR_W-1:0] csr_rdata;
    logic [CHAR_W-1:0] dma_data;
    rx_char_s rx_char = '0;
    logic [15:0] exp_rd[$];
    logic [7:0] exp_dma[$];
    int error_cnt = 0, n_compared = 0, cyc = 0;

    always #4 clk = ~clk;

    sync_rx_completion_status DUT (
        .clk(clk), .srst(srst), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .csr_rd(csr_rd),
        .csr_rdata(csr_rdata), .cnt_load_prim(cnt_load_prim), .cnt_load_sec(cnt_load_sec),
        .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready), .bit_oriented(bit_oriented),
        .rx_err(rx_err), .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
        .irq_req(irq_req), .tx_serial(tx_serial), .tx_clk_sel(tx_clk_sel), .line_rxd(line_rxd),
        .line_rx_clk(line_rx_clk), .line_txd(line_txd), .rx_serial(rx_serial), .rx_clk(rx_clk)
    );

    mem_sink sink (.clk(clk), .dma_valid(dma_valid), .dma_ready(dma_ready), .stall(stall));

    ////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result watcher: read word one edge after the read strobe, memory bytes on each pop
    always @(posedge clk) begin
        if (rd_p) chk(csr_rdata, exp_rd.pop_front());
        if (dma_valid === 1'b1 && dma_ready === 1'b1) chk(16'(dma_data), 16'(exp_dma.pop_front()));
        rd_p <= csr_rd;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus tasks, all driven at the falling edge
    task automatic wr(input logic [15:0] d);
        @(negedge clk);
        csr_wr = 1;
        csr_wdata = d;
        @(negedge clk);
        csr_wr = 0;
    endtask : wr

    task automatic rd(input logic [15:0] e);
        exp_rd.push_back(e);
        @(negedge clk);
        csr_rd = 1;
        @(negedge clk);
        csr_rd = 0;
        @(negedge clk);
    endtask : rd

    task automatic ld(input logic p, input logic s);
        @(negedge clk);
        cnt_load_prim = p;
        cnt_load_sec = s;
        @(negedge clk);
        cnt_load_prim = 0;
        cnt_load_sec = 0;
    endtask : ld

    // offers one character and returns once it was taken; valid stays up for back-to-back
    task automatic snd(input logic b, input logic l, input logic [2:0] rs);
        @(negedge clk);
        rx_valid = 1;
        rx_char = '{bufsel: b, last: l, resid: rs, data: 8'($urandom)};
        exp_dma.push_back(rx_char.data);
        while (rx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask : snd

    task automatic drain();
        @(negedge clk);
        rx_valid = 0;
        while (exp_dma.size() > 0) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask : drain

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'h040CE3D7));
        repeat (2) @(negedge clk);
        srst = 0;
        rd(16'h8080);
        chk(16'(irq_req), 16'h0000);
        wr(16'hFFFF);
        rd(16'h81A0);
        chk(16'(irq_req), 16'h0001);
        // loop on: receiver fed from transmitter, line pins ignored
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            ts = 1'($urandom);
            tc = 1'($urandom);
            tx_serial = ts;
            tx_clk_sel = tc;
            line_rxd = !ts;
            line_rx_clk = !tc;
            @(negedge clk);
            chk(16'({line_txd, rx_serial, rx_clk}), 16'({LINE_MARK, ts, tc}));
        end
        ld(1, 1);
        rd(16'h0120);
        chk(16'(irq_req), 16'h0000);
        // secondary message held in the staging buffer by a stalled memory
        bit_oriented = 1;
        @(negedge clk);
        snd(1, 0, 3'h0);
        snd(1, 0, 3'h0);
        snd(1, 1, 3'($urandom_range(1, 7)));
        @(negedge clk);
        rx_valid = 0;
        rd(16'h09A0);
        chk(16'(irq_req), 16'h0000);
        stall = 0;
        drain();
        chk(16'(irq_req), 16'h0001);
        // residual flag check after done, as the driver would do it
        bit_oriented = 0;
        rd(16'h01A0);
        bit_oriented = 1;
        ld(0, 1);
        rd(16'h0120);
        // primary message with a residual count, then a zero residual one after a count load
        snd(0, 0, 3'h0);
        snd(0, 1, 3'($urandom_range(1, 7)));
        drain();
        rd(16'h9120);
        ld(1, 0);
        rd(16'h0120);
        snd(0, 1, 3'h0);
        drain();
        rd(16'h8120);
        ld(1, 0);
        // memory held off: nine characters fill the head and the staging buffer
        stall = 1;
        for (int i = 0; i < 9; i++) snd(0, 1'(i == 8), 3'h0);
        @(negedge clk);
        rx_valid = 0;
        chk(16'(rx_ready), 16'h0000);
        chk(16'(irq_req), 16'h0000);
        rd(16'h8120);
        stall = 0;
        drain();
        chk(16'(irq_req), 16'h0001);
        ld(1, 0);
        // error summary requests only with the enable set
        rx_err = 1;
        @(negedge clk);
        chk(16'(irq_req), 16'h0001);
        wr(CSR_ZERO);
        chk(16'(irq_req), 16'h0000);
        rd(16'h4000);
        rx_err = 0;
        // loop off: line follows the transmitter, receiver follows the synchronised pins
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            ts = 1'($urandom);
            tc = 1'($urandom);
            lr = 1'($urandom);
            tx_serial = ts;
            line_rxd = tc;
            line_rx_clk = lr;
            repeat (6) @(negedge clk);
            chk(16'({line_txd, rx_serial, rx_clk}), 16'({ts, tc, lr}));
        end
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
